// ---- design/dcc_defines.svh ----
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// Register byte offsets
`define DCC_OFF_CTRL 8'h00
`define DCC_OFF_STAT 8'h04
`define DCC_OFF_MASK 8'h08
`define DCC_ADDR_W 8

// Control register field positions
`define DCC_B_IDLE 15
`define DCC_B_EVT2 13
`define DCC_B_EVT1 12
`define DCC_B_EN2 11
`define DCC_B_EN1 10
`define DCC_B_PAD2 9
`define DCC_B_PAD1 8
`define DCC_B_RES2 7
`define DCC_B_RES1 6
`define DCC_B_INV2 5
`define DCC_B_INV1 4
`define DCC_B_NEG2 3
`define DCC_B_POS2 2
`define DCC_B_NEG1 1
`define DCC_B_POS1 0

// Status and mask field positions
`define DCC_S_EV1 0
`define DCC_S_EV2 1

// Reset values
`define DCC_RST_CTRL 16'h0000
`define DCC_RST_IRQ 2'h0

// Bus responses
`define DCC_RESP_OK 2'h0
`define DCC_RESP_ERR 2'h2

`endif

// ---- design/dcc_pkg.sv ----
package dcc_pkg;

  typedef enum logic [1:0] {
    DCC_WR_IDLE = 2'b01,
    DCC_WR_RESP = 2'b10
  } dcc_wr_state_t;

  typedef enum logic [3:0] {
    DCC_SEL_CTRL = 4'b0001,
    DCC_SEL_STAT = 4'b0010,
    DCC_SEL_MASK = 4'b0100,
    DCC_SEL_NONE = 4'b1000
  } dcc_sel_t;

endpackage : dcc_pkg

// ---- design/dcc_channel.sv ----
`timescale 1ns/1ps
module dcc_channel
  import dcc_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic reset,
  // Settings
  input wire logic enable,
  input wire logic invert,
  // Analog comparison, high when VIN+ exceeds VIN-
  input wire logic rawCompare,
  // Results
  output logic result,
  output logic changeEvent
);

  logic next_result;

  // Disabled channel holds its result low and stays quiet
  always_comb begin
    next_result = enable & (rawCompare ^ invert);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      result <= 1'b0;
    end else begin
      result <= next_result;
    end
  end

  // Change seen only while enabled, so disabling records nothing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      changeEvent <= 1'b0;
    end else begin
      changeEvent <= enable & (next_result != result);
    end
  end

endmodule : dcc_channel

// ---- design/dcc_control.sv ----
// Functional notes
// R1 - Each comparator input chosen among its pins and the internal reference
// R2 - Idle suppress bit 15 blocks interrupts in idle, block stays enabled
// R3 - Bit 13 flags a change of comparator 2 output
// R4 - Bit 12 flags a change of comparator 1 output
// R5 - Bit 11 enables comparator 2
// R6 - Bit 10 enables comparator 1
// R7 - Bit 9 drives comparator 2 result onto its pad
// R8 - Bit 8 drives comparator 1 result onto its pad
// R9 - Read-only bit 7 shows comparator 2 result, inverted if asked
// R10 - Read-only bit 6 shows comparator 1 result, inverted if asked
// R11 - Bit 5 inverts comparator 2 output
// R12 - Bit 4 inverts comparator 1 output
// R13 - Bit 3 picks comparator 2 negative side: positive pin or negative pin
// R14 - Bit 2 picks comparator 2 positive side: positive pin or reference
// R15 - Bit 1 picks comparator 1 negative side: positive pin or negative pin
// R16 - Bit 0 picks comparator 1 positive side: positive pin or reference
// R17 - Event flag sticks until written zero, requests interrupt when unmasked unless idle with bit 15 set
// R18 - Disabled comparator reads zero, pad quiet, no events recorded
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_control
  import dcc_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic deviceIdle,
  // AXI4-Lite write address and data
  input wire logic [`DCC_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [`DCC_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Analog front end, raw comparisons
  input wire logic cmp1RawCompare,
  input wire logic cmp2RawCompare,
  // Analog front end, input routing and power
  output logic cmp1PosSelect,
  output logic cmp1NegSelect,
  output logic cmp2PosSelect,
  output logic cmp2NegSelect,
  output logic cmp1Enable,
  output logic cmp2Enable,
  // Pads
  output logic cmp1PadOut,
  output logic cmp1PadOe,
  output logic cmp2PadOut,
  output logic cmp2PadOe,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic dcc_sel_t decodeAddr(
    input logic [`DCC_ADDR_W-1:0] addr
  );
    if (addr == `DCC_OFF_CTRL) begin
      decodeAddr = DCC_SEL_CTRL;
    end else if (addr == `DCC_OFF_STAT) begin
      decodeAddr = DCC_SEL_STAT;
    end else if (addr == `DCC_OFF_MASK) begin
      decodeAddr = DCC_SEL_MASK;
    end else begin
      decodeAddr = DCC_SEL_NONE;
    end
  endfunction : decodeAddr

  // Byte-lane merge of a write onto the low half word
  function automatic logic [15:0] mergeLanes(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    mergeLanes[7:0] = strb[0] ? data[7:0] : old[7:0];
    mergeLanes[15:8] = strb[1] ? data[15:8] : old[15:8];
  endfunction : mergeLanes

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic idleSuppress;
  logic evt1Flag;
  logic evt2Flag;
  logic padEn1;
  logic padEn2;
  logic invert1;
  logic invert2;
  logic result1;
  logic result2;
  logic change1;
  logic change2;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic [15:0] ctrlValue;
  logic [15:0] statValue;
  logic [15:0] maskValue;
  logic [15:0] ctrlMerged;
  logic [15:0] statMerged;
  logic [15:0] maskMerged;

  always_comb begin
    ctrlValue = 16'h0000;
    ctrlValue[`DCC_B_IDLE] = idleSuppress;
    ctrlValue[`DCC_B_EVT2] = evt2Flag;
    ctrlValue[`DCC_B_EVT1] = evt1Flag;
    ctrlValue[`DCC_B_EN2] = cmp2Enable;
    ctrlValue[`DCC_B_EN1] = cmp1Enable;
    ctrlValue[`DCC_B_PAD2] = padEn2;
    ctrlValue[`DCC_B_PAD1] = padEn1;
    ctrlValue[`DCC_B_RES2] = result2;
    ctrlValue[`DCC_B_RES1] = result1;
    ctrlValue[`DCC_B_INV2] = invert2;
    ctrlValue[`DCC_B_INV1] = invert1;
    ctrlValue[`DCC_B_NEG2] = cmp2NegSelect;
    ctrlValue[`DCC_B_POS2] = cmp2PosSelect;
    ctrlValue[`DCC_B_NEG1] = cmp1NegSelect;
    ctrlValue[`DCC_B_POS1] = cmp1PosSelect;
    statValue = {14'h0000, irqStatus};
    maskValue = {14'h0000, irqMask};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel

  dcc_wr_state_t wrState;
  dcc_wr_state_t next_wrState;
  logic awHeld;
  logic wHeld;
  logic [`DCC_ADDR_W-1:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0] wStrbHeld;
  logic commit;
  dcc_sel_t wrSel;
  logic ctrlWrite;
  logic statWrite;
  logic maskWrite;

  // Address and data may arrive in either order; each waits alone
  assign awready = (wrState == DCC_WR_IDLE) & ~awHeld;
  assign wready = (wrState == DCC_WR_IDLE) & ~wHeld;
  assign commit = (wrState == DCC_WR_IDLE) & awHeld & wHeld;
  assign wrSel = decodeAddr(awAddrHeld);
  assign ctrlWrite = commit & (wrSel == DCC_SEL_CTRL);
  assign statWrite = commit & (wrSel == DCC_SEL_STAT);
  assign maskWrite = commit & (wrSel == DCC_SEL_MASK);
  assign ctrlMerged = mergeLanes(ctrlValue, wDataHeld, wStrbHeld);
  assign statMerged = mergeLanes(16'h0000, wDataHeld, wStrbHeld);
  assign maskMerged = mergeLanes(maskValue, wDataHeld, wStrbHeld);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      awHeld <= 1'b0;
      awAddrHeld <= '0;
    end else if (awvalid & awready) begin
      awHeld <= 1'b1;
      awAddrHeld <= awaddr;
    end else if (commit) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wHeld <= 1'b0;
      wDataHeld <= 32'h0000_0000;
      wStrbHeld <= 4'h0;
    end else if (wvalid & wready) begin
      wHeld <= 1'b1;
      wDataHeld <= wdata;
      wStrbHeld <= wstrb;
    end else if (commit) begin
      wHeld <= 1'b0;
    end
  end

  always_comb begin
    next_wrState = wrState;
    case (wrState)
      DCC_WR_IDLE: begin
        if (commit) begin
          next_wrState = DCC_WR_RESP;
        end
      end
      DCC_WR_RESP: begin
        if (bready) begin
          next_wrState = DCC_WR_IDLE;
        end
      end
      default: begin
        next_wrState = DCC_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrState <= DCC_WR_IDLE;
      bresp <= `DCC_RESP_OK;
    end else begin
      wrState <= next_wrState;
      if (commit) begin
        bresp <= (wrSel == DCC_SEL_NONE) ? `DCC_RESP_ERR : `DCC_RESP_OK;
      end
    end
  end

  assign bvalid = (wrState == DCC_WR_RESP);

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  dcc_sel_t rdSel;

  assign arready = ~rvalid;
  assign rdSel = decodeAddr(araddr);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `DCC_RESP_OK;
    end else if (arvalid & arready) begin
      rvalid <= 1'b1;
      rresp <= `DCC_RESP_OK;
      if (rdSel == DCC_SEL_CTRL) begin
        rdata <= {16'h0000, ctrlValue}; // R9 R10
      end else if (rdSel == DCC_SEL_STAT) begin
        rdata <= {16'h0000, statValue};
      end else if (rdSel == DCC_SEL_MASK) begin
        rdata <= {16'h0000, maskValue};
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= `DCC_RESP_ERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control settings

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      idleSuppress <= 1'b0;
    end else if (ctrlWrite) begin
      idleSuppress <= ctrlMerged[`DCC_B_IDLE]; // R2
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmp1Enable <= 1'b0;
      cmp2Enable <= 1'b0;
    end else if (ctrlWrite) begin
      cmp2Enable <= ctrlMerged[`DCC_B_EN2]; // R5
      cmp1Enable <= ctrlMerged[`DCC_B_EN1]; // R6
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      padEn1 <= 1'b0;
      padEn2 <= 1'b0;
    end else if (ctrlWrite) begin
      padEn2 <= ctrlMerged[`DCC_B_PAD2]; // R7
      padEn1 <= ctrlMerged[`DCC_B_PAD1]; // R8
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      invert1 <= 1'b0;
      invert2 <= 1'b0;
    end else if (ctrlWrite) begin
      invert2 <= ctrlMerged[`DCC_B_INV2]; // R11
      invert1 <= ctrlMerged[`DCC_B_INV1]; // R12
    end
  end

  // Analog mux steering straight from the stored bits
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmp1PosSelect <= 1'b0;
      cmp1NegSelect <= 1'b0;
      cmp2PosSelect <= 1'b0;
      cmp2NegSelect <= 1'b0;
    end else if (ctrlWrite) begin
      cmp2NegSelect <= ctrlMerged[`DCC_B_NEG2]; // R1 R13
      cmp2PosSelect <= ctrlMerged[`DCC_B_POS2]; // R1 R14
      cmp1NegSelect <= ctrlMerged[`DCC_B_NEG1]; // R1 R15
      cmp1PosSelect <= ctrlMerged[`DCC_B_POS1]; // R1 R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator channels

  dcc_channel u_cmp1 (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(cmp1Enable),
    .invert(invert1),
    .rawCompare(cmp1RawCompare),
    .result(result1),
    .changeEvent(change1)
  );

  dcc_channel u_cmp2 (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(cmp2Enable),
    .invert(invert2),
    .rawCompare(cmp2RawCompare),
    .result(result2),
    .changeEvent(change2)
  );

  // Result is held low while disabled, so the pad cannot toggle
  assign cmp1PadOut = result1; // R18
  assign cmp2PadOut = result2;
  assign cmp1PadOe = padEn1; // R8
  assign cmp2PadOe = padEn2; // R7

  ////////////////////////////////////////////////////////////////////////////
  // Event flags: a change in the clearing cycle still sets the flag

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      evt1Flag <= 1'b0;
      evt2Flag <= 1'b0;
    end else begin
      evt1Flag <= change1 |
        (evt1Flag & ~(ctrlWrite & ~ctrlMerged[`DCC_B_EVT1])); // R4 R17
      evt2Flag <= change2 |
        (evt2Flag & ~(ctrlWrite & ~ctrlMerged[`DCC_B_EVT2])); // R3 R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irqStatus <= `DCC_RST_IRQ;
    end else begin
      irqStatus[`DCC_S_EV1] <= change1 | (irqStatus[`DCC_S_EV1] &
        ~(statWrite & statMerged[`DCC_S_EV1]));
      irqStatus[`DCC_S_EV2] <= change2 | (irqStatus[`DCC_S_EV2] &
        ~(statWrite & statMerged[`DCC_S_EV2]));
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irqMask <= `DCC_RST_IRQ;
    end else if (maskWrite) begin
      irqMask <= maskMerged[1:0];
    end
  end

  // Idle gating acts on the output only; events keep being recorded
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(irqStatus & irqMask)) & ~(idleSuppress & deviceIdle); // R2 R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_ctrl_write;
    ctrlWrite;
  endsequence

  sequence s_lane_hi;
    s_ctrl_write ##0 wStrbHeld[1];
  endsequence

  sequence s_lane_lo;
    s_ctrl_write ##0 wStrbHeld[0];
  endsequence

  a_idle_quiet: assert property ( // R2
    irq |-> !($past(idleSuppress) && $past(deviceIdle)))
    else $error("interrupt raised while idle suppressed");

  a_evt2_sets: assert property ( // R3
    change2 |=> evt2Flag)
    else $error("comparator 2 change not flagged");

  a_evt1_sets: assert property ( // R4
    change1 |=> evt1Flag)
    else $error("comparator 1 change not flagged");

  a_en2_write: assert property ( // R5
    s_lane_hi |=> cmp2Enable == $past(wDataHeld[`DCC_B_EN2]))
    else $error("comparator 2 enable not written");

  a_en1_write: assert property ( // R6
    s_lane_hi |=> cmp1Enable == $past(wDataHeld[`DCC_B_EN1]))
    else $error("comparator 1 enable not written");

  a_pad2_cause: assert property ( // R7
    $changed(cmp2PadOe) |-> $past(ctrlWrite))
    else $error("pad 2 drive changed without a write");

  a_pad1_write: assert property ( // R8
    s_lane_hi |=> cmp1PadOe == $past(wDataHeld[`DCC_B_PAD1]))
    else $error("pad 1 drive not written");

  a_res2_invert: assert property ( // R9
    cmp2Enable && invert2 && cmp2RawCompare |=> !result2)
    else $error("comparator 2 inverted result wrong");

  a_res1_plain: assert property ( // R10
    cmp1Enable && !invert1 && cmp1RawCompare |=> result1)
    else $error("comparator 1 plain result wrong");

  a_pos1_select: assert property ( // R16
    s_lane_lo |=> cmp1PosSelect == $past(wDataHeld[`DCC_B_POS1]))
    else $error("comparator 1 positive select not written");

  a_neg2_select: assert property ( // R13
    s_lane_lo |=> cmp2NegSelect == $past(wDataHeld[`DCC_B_NEG2]))
    else $error("comparator 2 negative select not written");

  a_flag_sticky: assert property ( // R17
    evt1Flag && !ctrlWrite |=> evt1Flag)
    else $error("event flag dropped without a clear");

  a_off_silent: assert property ( // R18
    !cmp1Enable |=> !result1 && !change1)
    else $error("disabled comparator 1 active");

  a_irq_follows: assert property ( // R17
    irqStatus[`DCC_S_EV2] && irqMask[`DCC_S_EV2] && !deviceIdle |=> irq)
    else $error("unmasked event gave no interrupt");

endmodule : dcc_control

// ---- testbench/dcc_analog_model.sv ----
`timescale 1ns/1ps
module dcc_analog_model (
  // System
  input wire logic clk_sys,
  // Routing and power from the block
  input wire logic cmp1PosSelect,
  input wire logic cmp1NegSelect,
  input wire logic cmp2PosSelect,
  input wire logic cmp2NegSelect,
  input wire logic cmp1Enable,
  input wire logic cmp2Enable,
  // Pin and reference levels
  input wire logic [7:0] pos1Level,
  input wire logic [7:0] neg1Level,
  input wire logic [7:0] pos2Level,
  input wire logic [7:0] neg2Level,
  input wire logic [7:0] refLevel,
  // Raw comparisons
  output logic cmp1RawCompare,
  output logic cmp2RawCompare
);
  logic noise = 1'b0;
  logic [7:0] in1P;
  logic [7:0] in1N;
  logic [7:0] in2P;
  logic [7:0] in2N;

  // Unpowered comparator gives garbage, so it toggles every cycle
  always_ff @(posedge clk_sys) begin
    noise <= !noise;
  end

  always_comb begin
    in1P = cmp1PosSelect ? pos1Level : refLevel;
    in1N = cmp1NegSelect ? pos1Level : neg1Level;
    in2P = cmp2PosSelect ? pos2Level : refLevel;
    in2N = cmp2NegSelect ? pos2Level : neg2Level;
    cmp1RawCompare = cmp1Enable ? (in1P > in1N) : noise;
    cmp2RawCompare = cmp2Enable ? (in2P > in2N) : noise;
  end
endmodule : dcc_analog_model

// ---- testbench/tb_dual_comparator_control.sv ----
`timescale 1ns/1ps
`include "dcc_defines.svh"
module tb_dual_comparator_control;
  logic clk_sys, reset, deviceIdle;
  logic [`DCC_ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic cmp1RawCompare, cmp2RawCompare, cmp1Enable, cmp2Enable;
  logic cmp1PosSelect, cmp1NegSelect, cmp2PosSelect, cmp2NegSelect;
  logic cmp1PadOut, cmp1PadOe, cmp2PadOut, cmp2PadOe;
  logic [7:0] pos1Level, neg1Level, pos2Level, neg2Level, refLevel;
  int num_errors = 0;
  int compares = 0;

  dcc_control dut (.clk_sys, .reset, .deviceIdle, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .cmp1RawCompare, .cmp2RawCompare, .cmp1PosSelect, .cmp1NegSelect,
    .cmp2PosSelect, .cmp2NegSelect, .cmp1Enable, .cmp2Enable,
    .cmp1PadOut, .cmp1PadOe, .cmp2PadOut, .cmp2PadOe, .irq);

  dcc_analog_model analog (.clk_sys, .cmp1PosSelect, .cmp1NegSelect,
    .cmp2PosSelect, .cmp2NegSelect, .cmp1Enable, .cmp2Enable,
    .pos1Level, .neg1Level, .pos2Level, .neg2Level, .refLevel,
    .cmp1RawCompare, .cmp2RawCompare);

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = !clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  task end_of_test;
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask : check

  // Bounded edge wait; a hang ends the run as a failure
  task automatic tick(inout int n);
    @(posedge clk_sys);
    n++;
    if (n > 200) begin
      num_errors++;
      end_of_test();
    end
  endtask : tick

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      tick(n);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) tick(n);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do tick(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do tick(n); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'hf, r);
    check("bresp", {30'h0, r}, {30'h0, `DCC_RESP_OK});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_read(a, d, r);
    check("rresp", {30'h0, r}, {30'h0, `DCC_RESP_OK});
  endtask : rd

  ////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(`DCC_OFF_CTRL, d);
    check("ctrl reset", d, 32'h0000_0000);
    rd(`DCC_OFF_STAT, d);
    check("stat reset", d, 32'h0000_0000);
    rd(`DCC_OFF_MASK, d);
    check("mask reset", d, 32'h0000_0000);
    check("irq reset", {31'h0, irq}, 32'h0000_0000);
    axi_write(8'h0c, 32'h0000_ffff, 4'hf, r);
    check("bad wr", {30'h0, r}, {30'h0, `DCC_RESP_ERR});
    axi_read(8'h0c, d, r);
    check("bad rd", {30'h0, r}, {30'h0, `DCC_RESP_ERR});
    check("bad data", d, 32'h0000_0000);
  endtask : test_reset

  task automatic test_select;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      wr(`DCC_OFF_CTRL, 32'h0000_0c00 | (32'h1 << i));
      repeat (2) @(posedge clk_sys);
      check("select", {28'h0, cmp2NegSelect, cmp2PosSelect,
        cmp1NegSelect, cmp1PosSelect}, 32'h1 << i);
      check("enable", {30'h0, cmp2Enable, cmp1Enable}, 32'h3);
    end
    // Low lane only: enables in the upper byte must survive
    axi_write(`DCC_OFF_CTRL, 32'h0000_00ff, 4'h1, r);
    rd(`DCC_OFF_CTRL, d);
    check("strobe", d & 32'h0000_0f3f, 32'h0000_0c3f);
  endtask : test_select

  task automatic test_result;
    logic [31:0] d;
    logic [1:0] e;
    // Cmp1: pin 200 over 100; cmp2: reference 150 over 100
    for (int i = 0; i < 4; i++) begin
      wr(`DCC_OFF_CTRL, 32'h0000_0f01 | (i << 4));
      repeat (3) @(posedge clk_sys);
      e = 2'b11 ^ 2'(i);
      rd(`DCC_OFF_CTRL, d);
      check("results", {30'h0, d[7:6]}, {30'h0, e});
      check("pads", {30'h0, cmp2PadOut, cmp1PadOut}, {30'h0, e});
      check("pad oe", {30'h0, cmp2PadOe, cmp1PadOe}, 32'h3);
    end
    wr(`DCC_OFF_CTRL, 32'h0000_0c01);
    repeat (2) @(posedge clk_sys);
    check("pad off", {30'h0, cmp2PadOe, cmp1PadOe}, 32'h0);
  endtask : test_result

  task automatic test_events;
    logic [31:0] d;
    // Flags left over from the invert toggling must go before counting
    wr(`DCC_OFF_CTRL, 32'h0000_0c01);
    wr(`DCC_OFF_STAT, 32'h0000_0003);
    neg2Level <= 8'd200;
    repeat (4) @(posedge clk_sys);
    rd(`DCC_OFF_CTRL, d);
    check("evt cmp2", {30'h0, d[13:12]}, 32'h2);
    rd(`DCC_OFF_STAT, d);
    check("stat cmp2", d, 32'h0000_0002);
    neg1Level <= 8'd250;
    repeat (10) @(posedge clk_sys);
    rd(`DCC_OFF_CTRL, d);
    check("evt both", {30'h0, d[13:12]}, 32'h3);
    wr(`DCC_OFF_CTRL, 32'h0000_0c01);
    rd(`DCC_OFF_CTRL, d);
    check("evt clr", {30'h0, d[13:12]}, 32'h0);
    wr(`DCC_OFF_STAT, 32'h0000_0001);
    rd(`DCC_OFF_STAT, d);
    check("stat w1c", d, 32'h0000_0002);
  endtask : test_events

  task automatic test_irq;
    // Comparator 2 event still pending from the previous scenario
    wr(`DCC_OFF_MASK, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    check("irq cmp2", {31'h0, irq}, 32'h1);
    wr(`DCC_OFF_STAT, 32'h0000_0003);
    wr(`DCC_OFF_MASK, 32'h0000_0001);
    neg1Level <= 8'd100;
    repeat (6) @(posedge clk_sys);
    check("irq set", {31'h0, irq}, 32'h1);
    deviceIdle <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check("irq idle on", {31'h0, irq}, 32'h1);
    wr(`DCC_OFF_CTRL, 32'h0000_8c01);
    repeat (3) @(posedge clk_sys);
    check("irq idle", {31'h0, irq}, 32'h0);
    deviceIdle <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check("irq awake", {31'h0, irq}, 32'h1);
    wr(`DCC_OFF_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    check("irq mask", {31'h0, irq}, 32'h0);
    wr(`DCC_OFF_MASK, 32'h0000_0001);
    wr(`DCC_OFF_STAT, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    check("irq clr", {31'h0, irq}, 32'h0);
  endtask : test_irq

  task automatic test_disable;
    logic [31:0] d;
    wr(`DCC_OFF_CTRL, 32'h0000_0300);
    repeat (3) @(posedge clk_sys);
    wr(`DCC_OFF_STAT, 32'h0000_0003);
    neg1Level <= 8'd250;
    repeat (8) begin
      @(posedge clk_sys);
      check("quiet pad", {30'h0, cmp2PadOut, cmp1PadOut}, 32'h0);
    end
    rd(`DCC_OFF_CTRL, d);
    check("off ctrl", d, 32'h0000_0300);
    rd(`DCC_OFF_STAT, d);
    check("off stat", d, 32'h0000_0000);
  endtask : test_disable

  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    {deviceIdle, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    pos1Level = 8'd200;
    neg1Level = 8'd100;
    pos2Level = 8'd50;
    neg2Level = 8'd100;
    refLevel = 8'd150;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    test_reset();
    test_select();
    test_result();
    test_events();
    test_irq();
    test_disable();
    end_of_test();
  end
endmodule : tb_dual_comparator_control
